// ### common/mafp_pkg.sv
// Functional notes
// - Row address A10..A0 captured on strobe fall
// - Column address A18..A11 captured on strobe rise
// - Data bus released while output enable high
// - Write cycles take data and commands inbound
// - Reads drive array, status or identifier bytes
// - Written byte held internally after capture
// - Read drivers gated by output enable, strap and port reset
// - Write enable starts and qualifies writes
// - Ready/busy pin mirrors status bit seven
// - Strap low selects bus port, high parallel
// - Reserved pins become ready/busy and upper data
// - Reset pin blocks writes, returns to read-array
// - Initialize pin acts as output enable
// - Straps, protect pins, inputs form row address
package mafp_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int ADDR_W = ROW_W + COL_W;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  // Internal program time; least time, so the count rounds up
  localparam int PROG_TIME_NS = 10000;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = $clog2(PROG_CYC + 1);

  // ------------------------------------------------------------
  // Status layout, command codes, reset values
  // ------------------------------------------------------------
  localparam int READY_BIT = 7;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic READY_RST = 1'b1;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  // Nineteen-bit access address: column above row
  typedef struct packed {
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
  } mafp_addr_t;

  // Parallel port control strobes, all active low except the select
  typedef struct packed {
    logic rc_sel;
    logic oe_n;
    logic we_n;
  } mafp_ctl_t;

  // What a read returns
  typedef enum logic [1:0] {
    ST_ARRAY,
    ST_STATUS,
    ST_IDENT,
    ST_PROG_SETUP
  } mafp_mode_t;

endpackage

// ### rtl/mafp_addr_capture.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Row/column address capture on both strobe edges
// ------------------------------------------------------------
module mafp_addr_capture (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Port qualifier and pins
  input wire logic en,
  input wire logic rc_sel,
  input wire logic [mafp_pkg::ROW_W-1:0] a_pins,
  // Captured address
  output mafp_pkg::mafp_addr_t addr,
  output logic row_stb,
  output logic col_stb
);

  // Last strobe level, idle high so no edge is seen at release
  logic rc_prev_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rc_prev_r <= mafp_pkg::STROBE_IDLE;
    end else begin
      rc_prev_r <= rc_sel;
    end
  end

  // Edges only count while the port is selected and out of reset
  assign row_stb = en && rc_prev_r && !rc_sel;
  assign col_stb = en && !rc_prev_r && rc_sel;

  // Row half on the falling edge, column half on the rising edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr <= '0;
    end else begin
      if (row_stb) begin
        addr.row <= a_pins;
      end
      if (col_stb) begin
        addr.col <= a_pins[mafp_pkg::COL_W-1:0];
      end
    end
  end

  a_row_capture: assert property (@(posedge mclk) disable iff (!rst_n)
    (en && $fell(rc_sel)) |=> addr.row == $past(a_pins))
    else $error("row address not captured on strobe fall");

  a_col_capture: assert property (@(posedge mclk) disable iff (!rst_n)
    (en && $rose(rc_sel)) |=> addr.col == $past(a_pins[mafp_pkg::COL_W-1:0]))
    else $error("column address not captured on strobe rise");

endmodule

// ### rtl/mafp_byte_mem.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Byte array with one write port and a registered read
// ------------------------------------------------------------
module mafp_byte_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  // Elaboration check: an empty array or byte cannot be served
  if (AW < 1 || DW < 1) begin : g_bad_par
    $error("AW and DW must both be at least 1");
  end

  // Storage; no reset so it maps to RAM
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write side
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data leaves from a register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ### rtl/mafp_port.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Multiplexed-address parallel programming port
// ------------------------------------------------------------
module mafp_port #(
  // Low address bits that reach the demo array
  parameter int MEM_AW = 8,
  // Identifier byte; value is arbitrary
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Interface strap and port reset pin
  input wire logic interface_select_strap,
  input wire logic port_rst_n,
  // Parallel strobes
  input wire logic init_oe_n,
  input wire logic we_n,
  input wire logic rc_sel,
  // Shared address pins
  input wire logic [3:0] device_select_straps,
  input wire logic top_sector_lock,
  input wire logic sector_write_protect,
  input wire logic [4:0] general_inputs,
  // Lower data nibble, shared with the bus port lines
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe,
  // Reserved pins: upper data nibble and ready/busy
  input wire logic [3:0] reserved_pins_in,
  output logic [3:0] reserved_pins_out,
  output logic reserved_pins_oe,
  output logic ready_busy_out,
  output logic ready_busy_oe,
  // Hand-off to the bus port logic
  output logic low_pin_bus_port_sel
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (MEM_AW < 1 || MEM_AW > mafp_pkg::ADDR_W) begin : g_bad_aw
    $error("MEM_AW must lie between 1 and the address width");
  end

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic rst_meta_r; // First stage, read only by the second
  logic rst_sync_n; // Released copy used everywhere

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // Pin grouping
  // ------------------------------------------------------------
  mafp_pkg::mafp_ctl_t ctl; // Strobes as one bundle
  logic [mafp_pkg::ROW_W-1:0] a_pins; // Shared address lines
  logic [mafp_pkg::DATA_W-1:0] data_in; // Inbound byte

  assign ctl = '{rc_sel: rc_sel, oe_n: init_oe_n, we_n: we_n};
  // Straps low, protect pins next, general inputs on top
  assign a_pins = {general_inputs, sector_write_protect, top_sector_lock,
                   device_select_straps};
  assign data_in = {reserved_pins_in, lad_in};

  // ------------------------------------------------------------
  // Interface selection
  // ------------------------------------------------------------
  // The strap is registered; it is expected to sit still, so no
  // mid-access switch-over is handled beyond dropping the port
  logic par_r; // Parallel port selected
  logic active; // Selected and out of port reset

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      par_r <= 1'b0;
    end else begin
      par_r <= interface_select_strap;
    end
  end

  assign active = par_r && port_rst_n;
  assign low_pin_bus_port_sel = !par_r;

  // ------------------------------------------------------------
  // Address capture
  // ------------------------------------------------------------
  mafp_pkg::mafp_addr_t addr; // Current access address

  mafp_addr_capture u_cap (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .en(active),
    .rc_sel(ctl.rc_sel),
    .a_pins(a_pins),
    .addr(addr),
    .row_stb(),
    .col_stb()
  );

  // ------------------------------------------------------------
  // Write strobe and byte latch
  // ------------------------------------------------------------
  logic we_prev_r; // Write enable one cycle ago
  logic we_rise; // Accepted end of a write cycle
  logic [mafp_pkg::DATA_W-1:0] wr_byte_r; // Latched byte
  logic wr_pend_r; // Latched byte awaits decoding
  logic [mafp_pkg::BUSY_W-1:0] busy_cnt_r; // Program time left

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      we_prev_r <= mafp_pkg::STROBE_IDLE;
    end else begin
      we_prev_r <= ctl.we_n;
    end
  end

  // Writes end on the rising write enable; ignored while busy
  assign we_rise = active && !we_prev_r && ctl.we_n && (busy_cnt_r == '0);

  // Byte is held here so decoding never looks at the bus again
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_byte_r <= mafp_pkg::BYTE_RST;
    end else if (we_rise) begin
      wr_byte_r <= data_in;
    end
  end

  // One-cycle request to the command decoder
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= we_rise;
    end
  end

  // ------------------------------------------------------------
  // Command decoder
  // ------------------------------------------------------------
  mafp_pkg::mafp_mode_t mode_r; // What reads return
  logic prog_go; // Program the latched byte now

  assign prog_go = port_rst_n && wr_pend_r && (mode_r == mafp_pkg::ST_PROG_SETUP);

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_r <= mafp_pkg::ST_ARRAY;
    end else if (!port_rst_n) begin
      // Port reset returns to read-array
      mode_r <= mafp_pkg::ST_ARRAY;
    end else if (wr_pend_r) begin
      unique case (mode_r)
        // Second cycle of a program: byte goes to the array
        mafp_pkg::ST_PROG_SETUP: begin
          mode_r <= mafp_pkg::ST_STATUS;
        end
        // Any other mode: the byte is a command
        mafp_pkg::ST_ARRAY, mafp_pkg::ST_STATUS, mafp_pkg::ST_IDENT: begin
          unique case (wr_byte_r)
            mafp_pkg::CMD_READ_STATUS: begin
              mode_r <= mafp_pkg::ST_STATUS;
            end
            mafp_pkg::CMD_READ_ID: begin
              mode_r <= mafp_pkg::ST_IDENT;
            end
            mafp_pkg::CMD_PROGRAM: begin
              mode_r <= mafp_pkg::ST_PROG_SETUP;
            end
            // Unknown codes fall back to read-array, safest state
            default: begin
              mode_r <= mafp_pkg::ST_ARRAY;
            end
          endcase
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Program timer
  // ------------------------------------------------------------
  // Port reset aborts an operation in flight
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      busy_cnt_r <= '0;
    end else if (!port_rst_n) begin
      busy_cnt_r <= '0;
    end else if (prog_go) begin
      busy_cnt_r <= mafp_pkg::BUSY_W'(mafp_pkg::PROG_CYC);
    end else if (busy_cnt_r != '0) begin
      busy_cnt_r <= busy_cnt_r - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Array
  // ------------------------------------------------------------
  logic [mafp_pkg::DATA_W-1:0] mem_rdata; // Array byte at addr

  mafp_byte_mem #(
    .AW(MEM_AW),
    .DW(mafp_pkg::DATA_W)
  ) u_mem (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .wr_en(prog_go),
    .wr_addr(addr[MEM_AW-1:0]),
    .wr_data(wr_byte_r),
    .rd_addr(addr[MEM_AW-1:0]),
    .rd_data(mem_rdata)
  );

  // ------------------------------------------------------------
  // Status and ready/busy
  // ------------------------------------------------------------
  logic ready; // No program in progress
  logic [mafp_pkg::DATA_W-1:0] status_byte; // Status register view
  logic rb_r; // Registered pin copy

  assign ready = (busy_cnt_r == '0);

  always_comb begin
    status_byte = '0;
    status_byte[mafp_pkg::READY_BIT] = ready;
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rb_r <= mafp_pkg::READY_RST;
    end else begin
      rb_r <= status_byte[mafp_pkg::READY_BIT];
    end
  end

  assign ready_busy_out = rb_r;
  // Reserved pin only turns into an output in parallel mode
  assign ready_busy_oe = par_r;

  // ------------------------------------------------------------
  // Read data path
  // ------------------------------------------------------------
  logic [mafp_pkg::DATA_W-1:0] io_out_r; // Byte presented on reads

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      io_out_r <= mafp_pkg::BYTE_RST;
    end else begin
      unique case (mode_r)
        mafp_pkg::ST_ARRAY: begin
          io_out_r <= mem_rdata;
        end
        mafp_pkg::ST_IDENT: begin
          io_out_r <= ID_CODE;
        end
        // Status is also shown while waiting for program data
        mafp_pkg::ST_STATUS, mafp_pkg::ST_PROG_SETUP: begin
          io_out_r <= status_byte;
        end
      endcase
    end
  end

  // Drivers follow output enable; released in bus-port mode and in port reset
  assign lad_oe = active && !ctl.oe_n;
  assign reserved_pins_oe = active && !ctl.oe_n;
  assign lad_out = io_out_r[3:0];
  assign reserved_pins_out = io_out_r[7:4];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_we_accept;
    we_rise;
  endsequence

  sequence s_byte_held;
    (wr_byte_r == $past(data_in)) ##1 $stable(wr_byte_r);
  endsequence

  sequence s_prog_data;
    port_rst_n && wr_pend_r && (mode_r == mafp_pkg::ST_PROG_SETUP);
  endsequence

  a_oe_release: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    ctl.oe_n |-> (!lad_oe && !reserved_pins_oe))
    else $error("data bus driven while output enable high");

  a_oe_drives: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (par_r && port_rst_n && !init_oe_n) |-> (lad_oe && reserved_pins_oe))
    else $error("data bus not driven while initialize pin low");

  a_byte_latch: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    s_we_accept |=> s_byte_held)
    else $error("written byte not latched or not held");

  a_we_qualify: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    wr_pend_r |-> ($past(par_r) && $past(port_rst_n) && $past(we_n) && !$past(we_n, 2)))
    else $error("write taken without a write enable rise");

  a_prog_busy: assert property (@(posedge mclk) disable iff (!rst_sync_n || !port_rst_n)
    s_prog_data |=> ##1 (!ready_busy_out)[*8])
    else $error("ready/busy does not show a program in progress");

  a_status_read: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (mode_r == mafp_pkg::ST_STATUS)[*2] |-> (io_out_r[7] == $past(ready)))
    else $error("status read does not show ready bit");

  a_strap_lpc: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    !par_r |-> (!lad_oe && !reserved_pins_oe && !ready_busy_oe && low_pin_bus_port_sel))
    else $error("parallel port drives pins in bus-port mode");

  a_reserved_use: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    par_r |-> (ready_busy_oe && (reserved_pins_out == io_out_r[7:4]) &&
      (ready_busy_out == $past(ready))))
    else $error("reserved pins not reused in parallel mode");

  a_reset_block: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    !port_rst_n |=> (!wr_pend_r && mode_r == mafp_pkg::ST_ARRAY && ready))
    else $error("port reset did not block writes or restore read-array");

  a_row_map: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (active && $fell(rc_sel)) |=> (addr.row[10:6] == $past(general_inputs)) &&
      (addr.row[3:0] == $past(device_select_straps)))
    else $error("row address pins mapped wrongly");

endmodule

// ### verification/mafp_prog_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Programmer model driving the parallel pins
// ----------------------------------------------------------------
module mafp_prog_model (
  // Clock
  input wire logic mclk,
  // Resolved data bus as seen at the pins
  input wire logic [7:0] data_bus,
  // Strap and control pins
  output logic strap,
  output logic port_rst_n,
  output logic oe_n,
  output logic we_n,
  output logic rc_sel,
  // Multiplexed address and data drive
  output logic [10:0] a_pins,
  output logic [7:0] data_out
);
  // Last byte put on the bus and whether it is still driven
  logic [7:0] drv_q;
  logic drv_on;

  // Released bus shows the inverse of the last byte, so stale data never reads back
  assign data_out = drv_on ? drv_q : ~drv_q;

  // Idle levels at time zero
  initial begin
    strap = 1'b1;
    port_rst_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    rc_sel = 1'b1;
    a_pins = 11'h000;
    drv_q = 8'h00;
    drv_on = 1'b0;
  end

  // Step to just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Strap, port reset and output enable levels
  task automatic set_ctl(input logic s, input logic r, input logic o);
    tick(1);
    strap = s;
    port_rst_n = r;
    oe_n = o;
  endtask

  // Row on the falling strobe, then column on the rising strobe
  task automatic set_addr(input logic [10:0] row, input logic [7:0] col);
    tick(1);
    a_pins = row;
    rc_sel = 1'b0;
    tick(2);
    a_pins = {~row[10:8], col};
    rc_sel = 1'b1;
    tick(2);
  endtask

  // Byte held on the bus until the edge that sees write enable rise
  task automatic wr(input logic [7:0] b);
    tick(1);
    drv_q = b;
    drv_on = 1'b1;
    we_n = 1'b0;
    tick(1);
    we_n = 1'b1;
    tick(1);
    drv_on = 1'b0;
    tick(2);
  endtask

  // Read: enable outputs, take the byte once the output register settled
  task automatic rd(output logic [7:0] b);
    tick(1);
    oe_n = 1'b0;
    tick(3);
    b = data_bus;
    oe_n = 1'b1;
  endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_EXP = 8'hA5; // Arbitrary identifier value
  // Address table: entries differ in one pin group each, except 3B5 in two
  localparam logic [10:0] ROWS [5] = '{11'h7A5, 11'h3B5, 11'h785, 11'h7A5, 11'h7A2};
  localparam logic [7:0] COLS [5] = '{8'hFF, 8'h00, 8'h00, 8'hFE, 8'h00};
  localparam logic [7:0] DATS [5] = '{8'h3C, 8'hC3, 8'h96, 8'h69, 8'h5E};
  logic mclk, rstn, strap, port_rst_n, oe_n, we_n, rc_sel;
  logic [10:0] a_pins;
  logic [7:0] prog_data, bus;
  logic [3:0] lad_out, rp_out;
  logic lad_oe, rp_oe, rb_out, rb_oe, bus_sel;
  int bad_count, checks_done;

  // Pin level: the design wins while it drives, else the programmer side
  assign bus = {rp_oe ? rp_out : prog_data[7:4], lad_oe ? lad_out : prog_data[3:0]};

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  mafp_prog_model i_mafp_prog_model (.mclk(mclk), .data_bus(bus), .strap(strap),
    .port_rst_n(port_rst_n), .oe_n(oe_n), .we_n(we_n), .rc_sel(rc_sel),
    .a_pins(a_pins), .data_out(prog_data));

  // Twelve array bits so one column bit reaches the array
  mafp_port #(.MEM_AW(12), .ID_CODE(ID_EXP)) i_mafp_port (.mclk(mclk), .rstn(rstn),
    .interface_select_strap(strap), .port_rst_n(port_rst_n), .init_oe_n(oe_n),
    .we_n(we_n), .rc_sel(rc_sel), .device_select_straps(a_pins[3:0]),
    .top_sector_lock(a_pins[4]), .sector_write_protect(a_pins[5]),
    .general_inputs(a_pins[10:6]), .lad_in(bus[3:0]), .lad_out(lad_out),
    .lad_oe(lad_oe), .reserved_pins_in(bus[7:4]), .reserved_pins_out(rp_out),
    .reserved_pins_oe(rp_oe), .ready_busy_out(rb_out), .ready_busy_oe(rb_oe),
    .low_pin_bus_port_sel(bus_sel));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Full reset with the strap at the given level, outputs checked inside
  task automatic do_reset(input logic s);
    wait_clk(1);
    rstn = 1'b0;
    i_mafp_prog_model.set_ctl(s, 1'b1, 1'b1);
    wait_clk(16);
    chk("oe in reset", 8'h00, {7'h00, lad_oe});
    chk("ready in reset", 8'h01, {7'h00, rb_out});
    rstn = 1'b1;
    wait_clk(8);
  endtask

  // Single closing point of the run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Strap low hands the pins to the bus port even with output enable low
  task automatic t_strap();
    do_reset(1'b0);
    i_mafp_prog_model.set_ctl(1'b0, 1'b1, 1'b0);
    wait_clk(3);
    chk("bus port select", 8'h01, {7'h00, bus_sel});
    chk("ready oe strap low", 8'h00, {7'h00, rb_oe});
    chk("data oe strap low", 8'h00, {6'h00, lad_oe, rp_oe});
    do_reset(1'b1);
    chk("parallel select", 8'h00, {7'h00, bus_sel});
    chk("ready oe", 8'h01, {7'h00, rb_oe});
    $display("test strap done");
  endtask

  // Output drivers follow the initialize pin while selected and out of port reset
  task automatic t_oe();
    chk("oe high", 8'h00, {6'h00, lad_oe, rp_oe});
    i_mafp_prog_model.set_ctl(1'b1, 1'b1, 1'b0);
    wait_clk(1);
    chk("oe low", 8'h03, {6'h00, lad_oe, rp_oe});
    i_mafp_prog_model.set_ctl(1'b1, 1'b1, 1'b1);
    wait_clk(1);
    chk("oe high again", 8'h00, {6'h00, lad_oe, rp_oe});
    $display("test output enable done");
  endtask

  // Identifier and idle status reads, each after its own command
  task automatic t_ident();
    logic [7:0] b;
    i_mafp_prog_model.wr(mafp_pkg::CMD_READ_ID);
    i_mafp_prog_model.rd(b);
    chk("identifier", ID_EXP, b);
    i_mafp_prog_model.wr(mafp_pkg::CMD_READ_STATUS);
    i_mafp_prog_model.rd(b);
    chk("status idle", 8'h80, b);
    $display("test identifier done");
  endtask

  // Program each table entry, poll status, then read all back
  task automatic t_program();
    logic [7:0] s;
    int n;
    for (int k = 0; k < 5; k++) begin
      i_mafp_prog_model.set_addr(ROWS[k], COLS[k]);
      i_mafp_prog_model.wr(mafp_pkg::CMD_PROGRAM);
      i_mafp_prog_model.wr(DATS[k]);
      i_mafp_prog_model.rd(s);
      chk("status busy", 8'h00, s);
      chk("ready pin busy", 8'h00, {7'h00, rb_out});
      n = 0;
      while (s[7] !== 1'b1 && n < 400) begin
        i_mafp_prog_model.rd(s);
        n++;
      end
      if (n == 400) begin
        bad_count++;
        $display("[ERR] ready wait expected 1 seen 0");
        end_of_test();
      end
      chk("status ready", 8'h80, s);
      chk("ready pin ready", 8'h01, {7'h00, rb_out});
    end
    i_mafp_prog_model.wr(mafp_pkg::CMD_READ_ARRAY);
    for (int k = 0; k < 5; k++) begin
      i_mafp_prog_model.set_addr(ROWS[k], COLS[k]);
      i_mafp_prog_model.rd(s);
      chk("array byte", DATS[k], s);
    end
    $display("test program done");
  endtask

  // Port reset mid-program: drivers off, writes dropped, read-array after
  task automatic t_port_reset();
    logic [7:0] b;
    i_mafp_prog_model.set_addr(11'h000, 8'h00);
    i_mafp_prog_model.wr(mafp_pkg::CMD_PROGRAM);
    i_mafp_prog_model.wr(8'h11);
    i_mafp_prog_model.set_ctl(1'b1, 1'b0, 1'b0);
    wait_clk(2);
    chk("oe in port reset", 8'h00, {6'h00, lad_oe, rp_oe});
    i_mafp_prog_model.set_ctl(1'b1, 1'b0, 1'b1);
    i_mafp_prog_model.wr(mafp_pkg::CMD_READ_ID);
    i_mafp_prog_model.set_ctl(1'b1, 1'b1, 1'b1);
    wait_clk(3);
    chk("ready after port reset", 8'h01, {7'h00, rb_out});
    i_mafp_prog_model.rd(b);
    chk("read array after reset", 8'h11, b);
    $display("test port reset done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    bad_count = 0;
    checks_done = 0;
    t_strap();
    t_oe();
    t_ident();
    t_program();
    t_port_reset();
    end_of_test();
  end
endmodule
